// ---- logic/mmre_pkg.sv ----
// package for the mac management read/event/group block
// shared by the top module, the group address memory and its interface
package mmre_pkg;
  localparam int ADDR_W = 48;
  localparam int VAL_W = 48;
  localparam int GRP_DEPTH = 8;
  localparam int GRP_IDX_W = 3;
  localparam int GRP_CNT_W = 4;
  localparam int MASK_W = 8;
  localparam logic [ADDR_W-1:0] BCAST_ADDR = {ADDR_W{1'b1}};
  localparam logic [ADDR_W-1:0] NULL_ADDR = {ADDR_W{1'b0}};
  localparam logic [ADDR_W-1:0] ADDR_ZERO = {ADDR_W{1'b0}};
  localparam logic [VAL_W-1:0] VAL_ZERO = {VAL_W{1'b0}};
  localparam logic [MASK_W-1:0] MASK_RESET = 8'h00;

  typedef enum logic [2:0] {
    VAR_SUCCESSOR = 3'h0,
    VAR_PREDECESSOR = 3'h1,
    VAR_RETRY_COUNT = 3'h2,
    VAR_IN_RING = 3'h3,
    VAR_EVENT_MASK = 3'h4
  } mmre_var_t;

  typedef enum logic [1:0] {
    EVT_NONE = 2'h0,
    EVT_SUCC_CHANGE = 2'h1,
    EVT_SUCC_NULL = 2'h2
  } mmre_event_t;

  typedef enum logic [1:0] {
    FLT_NONE = 2'h0,
    FLT_DUP_ADDR = 2'h1,
    FLT_BAD_TX = 2'h2
  } mmre_fault_t;

  localparam logic STATUS_OK = 1'b1;
  localparam logic STATUS_FAIL = 1'b0;
endpackage

// ---- logic/mmre_grp_if.sv ----
// group address memory port bundle
// written by the top module, read by the memory module on the same clock; rdAddr is driven back by the memory
`timescale 1ns/100ps
interface mmre_grp_if;
  import mmre_pkg::*;
  logic wrEn;
  logic [GRP_IDX_W-1:0] wrIdx;
  logic [ADDR_W-1:0] wrAddr;
  logic [GRP_IDX_W-1:0] rdIdx;
  logic [ADDR_W-1:0] rdAddr;
  modport ctrl (output wrEn, output wrIdx, output wrAddr, output rdIdx, input rdAddr);
  modport mem (input wrEn, input wrIdx, input wrAddr, input rdIdx, output rdAddr);
endinterface

// ---- logic/mmre_grp_mem.sv ----
// group address memory: one write port, registered read port
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/100ps
module mmre_grp_mem
  import mmre_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  mmre_grp_if.mem grp
);
  logic [ADDR_W-1:0] mem_q [GRP_DEPTH];

  always_ff @(posedge clk)
  begin
    if (grp.wrEn)
    begin
      mem_q[grp.wrIdx] <= grp.wrAddr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      grp.rdAddr <= ADDR_ZERO;
    end
    else
    begin
      grp.rdAddr <= mem_q[grp.rdIdx];
    end
  end
endmodule

// ---- logic/mmre_top.sv ----
// mac station management read, event, fault and group filter block
// sits between the station management entity and the mac protocol machine;
// one clock, synchronous reset, all inputs from logic on the same clock
`timescale 1ns/100ps
module mmre_top
  import mmre_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // read and write requests
  input wire logic readReq,
  input wire logic writeReq,
  input wire mmre_pkg::mmre_var_t varId,
  input wire logic [mmre_pkg::VAL_W-1:0] writeValue,
  output logic confirmValid,
  output mmre_pkg::mmre_var_t confirmVarId,
  output logic [mmre_pkg::VAL_W-1:0] confirmValue,
  output logic confirmStatus,
  output logic writeConfirmValid,
  output logic writeConfirmStatus,
  // mac protocol machine state
  input wire logic [mmre_pkg::ADDR_W-1:0] successorAddress,
  input wire logic [mmre_pkg::ADDR_W-1:0] predecessorAddress,
  input wire logic [15:0] retryCount,
  input wire logic inRing,
  input wire logic enterOffline,
  input wire logic dupAddrSeen,
  input wire logic badTxSeen,
  output logic eventValid,
  output mmre_pkg::mmre_event_t eventType,
  output logic faultValid,
  output mmre_pkg::mmre_fault_t faultType,
  // group filter load, one address per beat
  input wire logic groupLoadStart,
  input wire logic groupAddrValid,
  input wire logic [mmre_pkg::ADDR_W-1:0] groupAddr,
  input wire logic groupLoadEnd,
  output logic groupConfirmValid,
  output logic groupConfirmStatus,
  // received frame filter
  input wire logic frameValid,
  input wire logic frameIsControl,
  input wire logic [mmre_pkg::ADDR_W-1:0] frameDest,
  input wire logic [mmre_pkg::ADDR_W-1:0] ownStationAddress,
  input wire logic monitorAllData,
  input wire logic monitorAllFrames,
  output logic frameAccept,
  output logic frameDone
);
  import mmre_pkg::*;

  mmre_grp_if grp ();

  mmre_grp_mem uMem (
    .clk(clk),
    .srst(srst),
    .grp(grp)
  );

  function automatic logic [VAL_W-1:0] padAddr(input logic [ADDR_W-1:0] a);
    padAddr = VAL_W'(a);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // read and write service

  logic [MASK_W-1:0] eventMask_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      confirmValid <= 1'b0;
      confirmVarId <= VAR_SUCCESSOR;
      confirmValue <= VAL_ZERO;
      confirmStatus <= STATUS_FAIL;
    end
    else
    begin
      confirmValid <= readReq;
      if (readReq)
      begin
        confirmVarId <= varId;
        confirmStatus <= STATUS_OK;
        unique case (varId)
          VAR_SUCCESSOR: confirmValue <= padAddr(successorAddress);
          VAR_PREDECESSOR: confirmValue <= padAddr(predecessorAddress);
          VAR_RETRY_COUNT: confirmValue <= VAL_W'(retryCount);
          VAR_IN_RING: confirmValue <= VAL_W'(inRing);
          default:
          begin
            confirmValue <= VAL_ZERO;
            confirmStatus <= STATUS_FAIL;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      eventMask_q <= MASK_RESET;
      writeConfirmValid <= 1'b0;
      writeConfirmStatus <= STATUS_FAIL;
    end
    else
    begin
      writeConfirmValid <= writeReq;
      if (writeReq)
      begin
        writeConfirmStatus <= (varId == VAR_EVENT_MASK) ? STATUS_OK : STATUS_FAIL;
        if (varId == VAR_EVENT_MASK)
        begin
          eventMask_q <= writeValue[MASK_W-1:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // events and faults

  logic [ADDR_W-1:0] prevSucc_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prevSucc_q <= NULL_ADDR;
    end
    else
    begin
      prevSucc_q <= successorAddress;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      eventValid <= 1'b0;
      eventType <= EVT_NONE;
    end
    else
    begin
      eventValid <= 1'b0;
      if (successorAddress != prevSucc_q && eventMask_q != MASK_RESET)
      begin
        eventValid <= 1'b1;
        eventType <= (successorAddress == NULL_ADDR) ? EVT_SUCC_NULL : EVT_SUCC_CHANGE;
      end
    end
  end

  // fault at offline entry
  // duplicate address wins when both causes are seen together
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      faultValid <= 1'b0;
      faultType <= FLT_NONE;
    end
    else
    begin
      faultValid <= 1'b0;
      if (enterOffline && (dupAddrSeen || badTxSeen))
      begin
        faultValid <= 1'b1;
        faultType <= dupAddrSeen ? FLT_DUP_ADDR : FLT_BAD_TX;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // group address load and frame filter

  typedef enum {F_IDLE, F_SCAN, F_WAIT} mmre_filt_t;
  mmre_filt_t filt_q;
  logic [GRP_CNT_W-1:0] loadCnt_q;
  logic [GRP_CNT_W-1:0] grpCount_q;
  logic [GRP_IDX_W-1:0] scanIdx_q;
  logic [ADDR_W-1:0] dest_q;
  logic loading_q;
  logic overflow_q;

  assign grp.wrEn = loading_q && groupAddrValid && loadCnt_q < GRP_CNT_W'(GRP_DEPTH);
  assign grp.wrIdx = loadCnt_q[GRP_IDX_W-1:0];
  assign grp.wrAddr = groupAddr;
  assign grp.rdIdx = scanIdx_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      loading_q <= 1'b0;
      loadCnt_q <= '0;
      grpCount_q <= '0;
      overflow_q <= 1'b0;
      groupConfirmValid <= 1'b0;
      groupConfirmStatus <= STATUS_FAIL;
    end
    else
    begin
      groupConfirmValid <= 1'b0;
      if (groupLoadStart)
      begin
        loading_q <= 1'b1;
        loadCnt_q <= '0;
        overflow_q <= 1'b0;
        grpCount_q <= '0;
      end
      else if (loading_q && groupLoadEnd)
      begin
        loading_q <= 1'b0;
        grpCount_q <= overflow_q ? '0 : loadCnt_q;
        groupConfirmValid <= 1'b1;
        groupConfirmStatus <= overflow_q ? STATUS_FAIL : STATUS_OK;
      end
      else if (loading_q && groupAddrValid)
      begin
        if (grp.wrEn)
        begin
          loadCnt_q <= loadCnt_q + GRP_CNT_W'(1);
        end
        else
        begin
          overflow_q <= 1'b1;
        end
      end
    end
  end

  // filter walk over the stored set
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      filt_q <= F_IDLE;
      scanIdx_q <= '0;
      dest_q <= ADDR_ZERO;
      frameAccept <= 1'b0;
      frameDone <= 1'b0;
    end
    else
    begin
      frameDone <= 1'b0;
      unique case (filt_q)
        F_IDLE:
        begin
          if (frameValid)
          begin
            dest_q <= frameDest;
            scanIdx_q <= '0;
            if (frameDest == BCAST_ADDR || frameDest == ownStationAddress ||
                monitorAllFrames || (monitorAllData && !frameIsControl) ||
                grpCount_q == '0 || loading_q)
            begin
              frameAccept <= frameDest == BCAST_ADDR || frameDest == ownStationAddress ||
                monitorAllFrames || (monitorAllData && !frameIsControl);
              frameDone <= 1'b1;
            end
            else
            begin
              filt_q <= F_WAIT;
            end
          end
        end
        F_WAIT:
        begin
          filt_q <= F_SCAN;
        end
        F_SCAN:
        begin
          if (grp.rdAddr == dest_q ||
              GRP_CNT_W'(scanIdx_q) + GRP_CNT_W'(1) >= grpCount_q)
          begin
            frameAccept <= grp.rdAddr == dest_q;
            frameDone <= 1'b1;
            filt_q <= F_IDLE;
          end
          else
          begin
            scanIdx_q <= scanIdx_q + GRP_IDX_W'(1);
            filt_q <= F_WAIT;
          end
        end
      endcase
    end
  end
endmodule

// ---- testbench/mmre_top_properties.sv ----
// checker on the top module ports of the management block
// assumes one clock domain and a synchronous active-high srst
`timescale 1ns/100ps
module mmre_top_properties
  import mmre_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic readReq,
  input wire logic writeReq,
  input wire mmre_pkg::mmre_var_t varId,
  input wire logic confirmValid,
  input wire mmre_pkg::mmre_var_t confirmVarId,
  input wire logic confirmStatus,
  input wire logic writeConfirmValid,
  input wire logic writeConfirmStatus,
  input wire logic [mmre_pkg::ADDR_W-1:0] successorAddress,
  input wire logic eventValid,
  input wire mmre_pkg::mmre_event_t eventType,
  input wire logic enterOffline,
  input wire logic dupAddrSeen,
  input wire logic badTxSeen,
  input wire logic faultValid,
  input wire mmre_pkg::mmre_fault_t faultType,
  input wire logic groupLoadEnd,
  input wire logic groupConfirmValid,
  input wire logic frameValid,
  input wire logic [mmre_pkg::ADDR_W-1:0] frameDest,
  input wire logic frameDone,
  input wire logic frameAccept
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  AST_RD_CONF: assert property (readReq |=> confirmValid && confirmVarId == $past(varId))
    else $error("read confirm wrong");
  AST_RD_FAIL: assert property (readReq && varId > VAR_IN_RING |=> !confirmStatus)
    else $error("unreadable variable answered success");
  AST_WR_CONF: assert property (writeReq |=> writeConfirmValid &&
    writeConfirmStatus == ($past(varId) == VAR_EVENT_MASK)) else $error("write confirm wrong");
  AST_EVT: assert property (eventValid |->
    $past(successorAddress) != $past(successorAddress, 2)
    && eventType == ($past(successorAddress) == NULL_ADDR ? EVT_SUCC_NULL : EVT_SUCC_CHANGE))
    else $error("event without matching successor change");
  AST_FLT: assert property (enterOffline && (dupAddrSeen || badTxSeen) |=>
    faultValid && faultType == ($past(dupAddrSeen) ? FLT_DUP_ADDR : FLT_BAD_TX))
    else $error("fault type wrong");
  AST_FLT_CAUSE: assert property (faultValid |-> $past(enterOffline))
    else $error("fault without offline entry");
  AST_GRP_CONF: assert property (groupConfirmValid |-> $past(groupLoadEnd))
    else $error("group confirm without load end");
  AST_BCAST: assert property (frameValid && frameDest == BCAST_ADDR |=>
    frameDone && frameAccept) else $error("broadcast not accepted");
endmodule
bind mmre_top mmre_top_properties u_props (.*);

// ---- testbench/mmre_sme_model.sv ----
// station management model issuing read and write requests
// assumes the block confirms within a few cycles of each request
`timescale 1ns/100ps
module mmre_sme_model
  import mmre_pkg::*;
(
  input wire logic clk,
  output logic readReq,
  output logic writeReq,
  output mmre_pkg::mmre_var_t varId,
  output logic [mmre_pkg::VAL_W-1:0] writeValue,
  input wire logic confirmValid,
  input wire logic writeConfirmValid
);
  initial
  begin
    readReq = 1'b0;
    writeReq = 1'b0;
    varId = VAR_SUCCESSOR;
    writeValue = VAL_ZERO;
  end
  // fields go to inverse values once released, so stale data cannot pass
  task automatic req(input logic wr, input mmre_var_t v, input logic [VAL_W-1:0] d,
    output logic ok);
    ok = 1'b0;
    @(negedge clk);
    readReq = !wr;
    writeReq = wr;
    varId = v;
    writeValue = d;
    for (int n = 0; n < 4 && !ok; n++)
    begin
      @(negedge clk);
      readReq = 1'b0;
      writeReq = 1'b0;
      varId = mmre_var_t'(~v);
      writeValue = ~d;
      ok = wr ? writeConfirmValid === 1'b1 : confirmValid === 1'b1;
    end
  endtask
endmodule

// ---- testbench/mmre_top_bench.sv ----
// self-checking bench for the management block
// drives inputs at the falling edge; the model issues read and write requests
`timescale 1ns/100ps
module mmre_top_bench;
  import mmre_pkg::*;
  logic clk = 1'b0, srst = 1'b1, ok;
  logic readReq, writeReq, confirmValid, confirmStatus, writeConfirmValid, writeConfirmStatus;
  mmre_var_t varId, confirmVarId;
  logic [VAL_W-1:0] writeValue, confirmValue;
  logic [ADDR_W-1:0] successorAddress = 48'h11, predecessorAddress = 48'h22;
  logic [ADDR_W-1:0] groupAddr = 48'h0, frameDest = 48'h0, ownStationAddress = 48'haa;
  logic [15:0] retryCount = 16'h5;
  logic inRing = 1'b1, enterOffline = 1'b0, dupAddrSeen = 1'b0, badTxSeen = 1'b0;
  logic groupLoadStart = 1'b0, groupAddrValid = 1'b0, groupLoadEnd = 1'b0, frameValid = 1'b0;
  logic frameIsControl = 1'b0, monitorAllData = 1'b0, monitorAllFrames = 1'b0;
  logic eventValid, faultValid, groupConfirmValid, groupConfirmStatus, frameAccept, frameDone;
  mmre_event_t eventType;
  mmre_fault_t faultType;
  int fail_count = 0, compares = 0;
  typedef struct {mmre_var_t v; logic st; logic [VAL_W-1:0] val;} mmre_row_t;
  mmre_row_t rows [6] = '{'{VAR_SUCCESSOR, 1'b1, 48'h11}, '{VAR_PREDECESSOR, 1'b1, 48'h22},
    '{VAR_RETRY_COUNT, 1'b1, 48'h5}, '{VAR_IN_RING, 1'b1, 48'h1},
    '{VAR_EVENT_MASK, 1'b0, 48'h0}, '{mmre_var_t'(3'h5), 1'b0, 48'h0}};
  always #2 clk = ~clk;
  mmre_top DUT (.*);
  mmre_sme_model sme (.*);
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic c, input string m);
    compares++;
    if (c !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH %0t: %s", $time, m);
    end
  endtask
  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic pul(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic wt(ref logic s);
    for (int n = 0; n < 40 && s !== 1'b1; n++)
      @(negedge clk);
    if (s !== 1'b1)
    begin
      chk(1'b0, "no answer");
      close_out();
    end
  endtask
  task automatic frm(input logic [ADDR_W-1:0] d, input logic c, input logic e);
    frameDest = d;
    frameIsControl = c;
    pul(frameValid);
    frameDest = ~d;
    wt(frameDone);
    chk(frameAccept === e, "frame accept");
  endtask
  task automatic grp(input int n, input logic [ADDR_W-1:0] b, input logic e);
    pul(groupLoadStart);
    for (int i = 0; i < n; i++)
    begin
      groupAddr = b + ADDR_W'(i);
      pul(groupAddrValid);
    end
    groupAddr = ~groupAddr;
    pul(groupLoadEnd);
    wt(groupConfirmValid);
    chk(groupConfirmStatus === e, "group status");
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    chk(confirmValid === 1'b0 && eventValid === 1'b0 && faultValid === 1'b0, "reset outputs");
    foreach (rows[i])
    begin
      sme.req(1'b0, rows[i].v, VAL_ZERO, ok);
      chk(ok && confirmVarId === rows[i].v && confirmStatus === rows[i].st, "read");
      if (rows[i].st)
        chk(confirmValue === rows[i].val, "read value");
      if (!ok)
        close_out();
    end
    $display("reads done");
    successorAddress = 48'h33;
    @(negedge clk);
    chk(eventValid === 1'b0, "event while masked");
    sme.req(1'b1, VAR_SUCCESSOR, 48'h1, ok);
    chk(ok && writeConfirmStatus === STATUS_FAIL, "write refused");
    if (!ok)
      close_out();
    sme.req(1'b1, VAR_EVENT_MASK, 48'h1, ok);
    chk(ok && writeConfirmStatus === STATUS_OK, "mask write");
    if (!ok)
      close_out();
    successorAddress = 48'h44;
    @(negedge clk);
    chk(eventValid === 1'b1 && eventType === EVT_SUCC_CHANGE, "successor change");
    successorAddress = NULL_ADDR;
    @(negedge clk);
    chk(eventValid === 1'b1 && eventType === EVT_SUCC_NULL, "successor null");
    // a mid-run reset must clear the mask again
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    successorAddress = 48'h55;
    @(negedge clk);
    chk(eventValid === 1'b0, "event after reset");
    $display("events done");
    for (int i = 1; i < 4; i++)
    begin
      {badTxSeen, dupAddrSeen} = 2'(i);
      pul(enterOffline);
      chk(faultValid === 1'b1 &&
        faultType === (dupAddrSeen ? FLT_DUP_ADDR : FLT_BAD_TX), "fault");
    end
    @(negedge clk);
    chk(faultValid === 1'b0, "fault while online");
    $display("faults done");
    grp(2, 48'ha0, STATUS_OK);
    frm(48'ha1, 1'b0, 1'b1);
    frm(48'ha9, 1'b0, 1'b0);
    frm(BCAST_ADDR, 1'b1, 1'b1);
    frm(48'haa, 1'b0, 1'b1);
    monitorAllData = 1'b1;
    frm(48'ha9, 1'b0, 1'b1);
    monitorAllData = 1'b0;
    monitorAllFrames = 1'b1;
    frm(48'ha9, 1'b1, 1'b1);
    monitorAllFrames = 1'b0;
    grp(9, 48'hb0, STATUS_FAIL);
    frm(48'ha0, 1'b0, 1'b0);
    grp(8, 48'hb0, STATUS_OK);
    frm(48'hb7, 1'b0, 1'b1);
    frm(48'ha1, 1'b0, 1'b0);
    grp(0, 48'h0, STATUS_OK);
    frm(48'hb0, 1'b0, 1'b0);
    frm(BCAST_ADDR, 1'b0, 1'b1);
    $display("group filter done");
    close_out();
  end
endmodule
